// file: tb/udt_trip_timer_tb.sv
// self-checking bench for the definite-time trip timer
// assumes the package, the design files and the upstream model come first
`timescale 1ns/10ps
module udt_trip_timer_tb;
  import udt_pkg::*;
  localparam int TK = 10;
  logic          clk, resetn, zone, blk, detect_en, inhibit;
  logic          pickup, trip, irq, reg_wr, reg_rd;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rv, e1;
  logic [2:0]    ops [3] = '{3'h0, OP_DISABLE, 3'h7};
  int            mismatches, comparisons, ms, dt;
  time           t0;

  udt_upstream_model up (.clk(clk), .resetn(resetn), .zone_in(zone),
    .block_in(blk), .detect_en(detect_en), .inhibit(inhibit));
  udt_trip_timer #(.TICK_CYC(TK)) dut (.clk(clk), .resetn(resetn),
    .detect_en(detect_en), .inhibit(inhibit), .pickup(pickup),
    .trip(trip), .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [DW-1:0] exp,
                          input logic [DW-1:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe edge
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic set_in(input logic z, input logic b);
    @(posedge clk);
    zone <= z;
    blk  <= b;
    t0 = $time;
  endtask

  task automatic wait_for(input bit use_trip, input logic val, input int lim);
    int k;
    k = 0;
    while (((use_trip ? trip : pickup) !== val) && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    dt = int'(($time - t0) / 10);
    if (k >= lim) begin
      mismatches++;
      $display("CHECK FAILED wait trip=%0b expected %b seen timeout",
               use_trip, val);
      end_sim();
    end
  endtask

  function automatic bit in_rng(int v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction

  function automatic int exp_ratio(int e_ms, int steps);
    return e_ms * int'(PCT_FULL) / (steps * STEP_MS);
  endfunction

  initial begin
    resetn = 1'b0;
    zone = 1'b0;
    blk = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    comparisons = 0;
    t0 = 0;
    dt = 0;
    void'($urandom(30));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk_bit("pickup", 1'b0, pickup);
    chk_bit("trip", 1'b0, trip);
    rd(OFF_CTRL, rv);
    chk_word("ctrl", {26'h0, BLK_FREEZE, 1'b0, OP_ENABLE}, rv);
    rd(OFF_TRIP_DLY, rv);
    chk_word("trip_dly", {17'h0, TRIP_STEPS_RST}, rv);
    rd(OFF_RST_DLY, rv);
    chk_word("rst_dly", {19'h0, RST_STEPS_RST}, rv);
    rd(8'h20, rv);
    chk_word("unmapped", 32'h0, rv);
    wr(OFF_TRIP_DLY, 32'h1);
    rd(OFF_TRIP_DLY, rv);
    chk_word("trip_clamp", {17'h0, TRIP_STEPS_MIN}, rv);
    $display("test reset_values done");

    ms = STEP_MS * $urandom_range(4, 8);
    wr(OFF_TRIP_DLY, DW'(ms / STEP_MS));
    set_in(1'b1, 1'b0);
    wait_for(1'b0, 1'b1, 10);
    chk_bit("pickup_delay", 1'b1, in_rng(dt, 1, 3));
    chk_bit("irq_masked", 1'b0, irq);
    wr(OFF_IRQ_MASK, 32'h7);
    #1;
    chk_bit("irq_unmasked", 1'b1, irq);
    rd(OFF_IRQ_STAT, rv);
    chk_word("irq_pickup", 32'h1, rv);
    chk_bit("irq_cleared", 1'b0, irq);
    wait_for(1'b1, 1'b1, ms * TK + 20);
    chk_bit("trip_time", 1'b1, in_rng(dt, ms * TK, ms * TK + 8));
    rd(OFF_IRQ_STAT, rv);
    chk_word("irq_trip", 32'h2, rv);
    rd(OFF_RATIO, rv);
    chk_word("ratio_full", {18'h0, PCT_FULL}, rv);
    set_in(1'b0, 1'b0);
    wait_for(1'b1, 1'b0, 5);
    chk_bit("pickup_clear", 1'b0, pickup);
    $display("test trip_timing done");

    wr(OFF_TRIP_DLY, 32'ha);
    ms = $urandom_range(30, 40);
    wr(OFF_RST_DLY, DW'(ms));
    set_in(1'b1, 1'b0);
    repeat (300) @(posedge clk);
    set_in(1'b0, 1'b0);
    repeat (20) @(posedge clk);
    rd(OFF_ELAPSED, e1);
    chk_bit("elapsed_ms", 1'b1, in_rng(int'(e1), 28, 31));
    repeat (300) @(posedge clk);
    rd(OFF_ELAPSED, rv);
    chk_word("elapsed_held", e1, rv);
    chk_bit("pickup_held", 1'b1, pickup);
    rd(OFF_RATIO, rv);
    chk_word("ratio", DW'(exp_ratio(int'(e1), 10)), rv);
    wait_for(1'b0, 1'b0, ms * 10 * TK);
    chk_bit("reset_time", 1'b1,
            in_rng(dt, ms * 10 * TK - TK, ms * 10 * TK + 8));
    rd(OFF_ELAPSED, rv);
    chk_word("elapsed_clear", 32'h0, rv);
    rd(OFF_IRQ_STAT, rv);
    chk_word("irq_reset", 32'h5, rv);
    wr(OFF_RST_DLY, 32'h0);
    $display("test drop_off done");

    set_in(1'b1, 1'b0);
    repeat (400) @(posedge clk);
    set_in(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    rd(OFF_ELAPSED, e1);
    repeat (400) @(posedge clk);
    rd(OFF_ELAPSED, rv);
    chk_word("elapsed_frozen", e1, rv);
    chk_bit("pickup_frozen", 1'b1, pickup);
    chk_bit("trip_frozen", 1'b0, trip);
    ms = (100 - int'(e1)) * TK;
    set_in(1'b1, 1'b0);
    wait_for(1'b1, 1'b1, ms + 20);
    chk_bit("trip_resume", 1'b1, in_rng(dt, ms - TK, ms + 8));
    set_in(1'b0, 1'b0);
    wait_for(1'b1, 1'b0, 5);
    $display("test freeze done");

    wr(OFF_CTRL, 32'h11);
    set_in(1'b1, 1'b0);
    repeat (300) @(posedge clk);
    set_in(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    chk_bit("blocked_pickup", 1'b0, pickup);
    rd(OFF_ELAPSED, rv);
    chk_word("blocked_elapsed", 32'h0, rv);
    repeat (1200) @(posedge clk);
    chk_bit("blocked_trip", 1'b0, trip);
    set_in(1'b1, 1'b0);
    wait_for(1'b0, 1'b1, 10);
    set_in(1'b0, 1'b0);
    wait_for(1'b0, 1'b0, 10);
    $display("test block_all done");

    wr(OFF_CTRL, 32'h21);
    set_in(1'b1, 1'b1);
    wait_for(1'b0, 1'b1, 10);
    repeat (1100) @(posedge clk);
    chk_bit("trip_blocked", 1'b0, trip);
    rd(OFF_ELAPSED, rv);
    chk_bit("timing_runs", 1'b1, int'(rv) >= 100);
    set_in(1'b1, 1'b0);
    wait_for(1'b1, 1'b1, 5);
    set_in(1'b0, 1'b0);
    wait_for(1'b1, 1'b0, 5);
    $display("test block_trip done");

    foreach (ops[i]) begin
      wr(OFF_CTRL, {29'h0, ops[i]});
      set_in(1'b1, 1'b0);
      repeat (100) @(posedge clk);
      chk_bit("disabled_pickup", 1'b0, pickup);
      rd(OFF_STATUS, rv);
      chk_word("disabled_status", 32'h0, rv);
      set_in(1'b0, 1'b0);
    end
    wr(OFF_CTRL, 32'h1);
    set_in(1'b1, 1'b0);
    wait_for(1'b0, 1'b1, 10);
    set_in(1'b0, 1'b0);
    wait_for(1'b0, 1'b0, 10);
    $display("test operation done");

    // pulses shorter than the trip delay never trip
    repeat (6) begin
      ms = $urandom_range(150, 900);
      set_in(1'b1, 1'b0);
      wait_for(1'b0, 1'b1, 10);
      repeat (ms) @(posedge clk);
      chk_bit("short_no_trip", 1'b0, trip);
      set_in(1'b0, 1'b0);
      wait_for(1'b0, 1'b0, 10);
    end
    $display("test random_pulses done");
    end_sim();
  end
endmodule

// file: tb/udt_upstream_model.sv
// stand-in for the upstream impedance detector and the block source
// assumes the bench drives zone_in and block_in on clk
`timescale 1ns/10ps
module udt_upstream_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic zone_in,
  input  wire logic block_in,
  output logic      detect_en,
  output logic      inhibit
);
  // registered levels, as a real detector on clk would give them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      detect_en <= 1'b0;
      inhibit   <= 1'b0;
    end else begin
      detect_en <= zone_in;
      inhibit   <= block_in;
    end
  end
endmodule

// file: verilog/udt_ms_tick.sv
// millisecond tick divider for the trip timer
// assumes clk at the rate given in the package, resetn asynchronous
`timescale 1ns/10ps
module udt_ms_tick #(
  parameter int CYC = udt_pkg::TICK_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   resetn,
  udt_tick_if.src     tk
);
  import udt_pkg::*;

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_q;
  wire         wrap = (cnt_q == 32'(CYC - 1));

  // restarts while idle so the first tick is a full period away
  assign cnt_d = !tk.run ? 32'h0 : (wrap ? 32'h0 : cnt_q + 32'h1);
  assign tk.tick = tick_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tk.run && wrap;
    end
  end

  a_tick_single: assert property (@(posedge clk) disable iff (!resetn)
    tick_q |=> !tick_q)
    else $error("tick longer than one cycle");
endmodule

// file: verilog/udt_pkg.sv
// constants and types for the definite-time underimpedance trip timer
// assumes a 100 MHz system clock and a 1 ms timing tick
package udt_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STEP_MS = 10;

  localparam int AW = 8;
  localparam int DW = 32;
  localparam int MS_W = 18;
  localparam int PCT_W = 14;
  localparam int TRIP_STEP_W = 15;
  localparam int RST_STEP_W = 13;
  localparam int IRQ_W = 3;

  // register byte offsets
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_TRIP_DLY = 8'h04;
  localparam logic [AW-1:0] OFF_RST_DLY = 8'h08;
  localparam logic [AW-1:0] OFF_STATUS = 8'h0c;
  localparam logic [AW-1:0] OFF_RATIO = 8'h10;
  localparam logic [AW-1:0] OFF_ELAPSED = 8'h14;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h1c;

  // control field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_MSB = 2;
  localparam int CTRL_BLK_LSB = 4;
  localparam int CTRL_BLK_MSB = 5;

  // operation setting codes
  localparam logic [2:0] OP_ENABLE = 3'h1;
  localparam logic [2:0] OP_DISABLE = 3'h5;

  // blocking mode codes
  localparam logic [1:0] BLK_FREEZE = 2'h0;
  localparam logic [1:0] BLK_ALL = 2'h1;
  localparam logic [1:0] BLK_TRIP = 2'h2;

  // delay settings, in 10 ms steps
  localparam logic [TRIP_STEP_W-1:0] TRIP_STEPS_RST = 15'h0014;
  localparam logic [TRIP_STEP_W-1:0] TRIP_STEPS_MIN = 15'h0004;
  localparam logic [TRIP_STEP_W-1:0] TRIP_STEPS_MAX = 15'h4e20;
  localparam logic [RST_STEP_W-1:0] RST_STEPS_RST = 13'h0002;
  localparam logic [RST_STEP_W-1:0] RST_STEPS_MAX = 13'h1770;

  // ratio in hundredths of a percent
  localparam logic [PCT_W-1:0] PCT_FULL = 14'h2710;

  // interrupt status bits
  localparam int IRQ_PICKUP = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_DROP = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PICKUP,
    ST_DROPOFF,
    ST_TRIPPED
  } udt_state_e;
endpackage

// file: verilog/udt_tick_if.sv
// tick link between the trip timer and its millisecond divider
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface udt_tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport snk (output run, input tick);
endinterface

// file: verilog/udt_trip_timer.sv
// definite-time pickup, trip and reset timer with blocking
// assumes detect_en and inhibit come from logic on clk
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
module udt_trip_timer #(
  parameter int TICK_CYC = udt_pkg::TICK_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   detect_en,
  input  wire logic                   inhibit,
  output logic                        pickup,
  output logic                        trip,
  output logic                        irq,
  input  wire logic [udt_pkg::AW-1:0] reg_addr,
  input  wire logic [udt_pkg::DW-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [udt_pkg::DW-1:0] reg_rdata
);
  import udt_pkg::*;

  udt_tick_if tk ();

  udt_ms_tick #(
    .CYC (TICK_CYC)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tk     (tk)
  );

  // settings
  logic [2:0]             op_q;
  logic [1:0]             blk_mode_q;
  logic [TRIP_STEP_W-1:0] trip_steps_q;
  logic [RST_STEP_W-1:0]  rst_steps_q;
  logic [IRQ_W-1:0]       irq_mask_q;
  logic [IRQ_W-1:0]       irq_stat_q;
  logic [IRQ_W-1:0]       irq_stat_d;

  // timing state
  udt_state_e             st_q;
  udt_state_e             st_d;
  logic [MS_W-1:0]        op_cnt_q;
  logic [MS_W-1:0]        op_cnt_d;
  logic [MS_W-1:0]        rst_cnt_q;
  logic [MS_W-1:0]        rst_cnt_d;
  logic [PCT_W-1:0]       pct_q;
  logic [PCT_W-1:0]       pct_d;
  logic                   pickup_q;
  logic                   trip_q;
  logic [DW-1:0]          rdata_q;

  // decode of settings and blocking
  wire enabled   = (op_q == OP_ENABLE);
  wire frz       = enabled && inhibit && (blk_mode_q == BLK_FREEZE);
  wire blk_all   = inhibit && (blk_mode_q == BLK_ALL);
  wire blk_trip  = inhibit && (blk_mode_q == BLK_TRIP);
  wire run       = enabled && !blk_all;
  wire tick      = tk.tick;

  wire [MS_W-1:0] trip_ms = MS_W'(trip_steps_q * STEP_MS);
  wire [MS_W-1:0] rst_ms  = MS_W'(rst_steps_q * STEP_MS);
  wire op_done   = (op_cnt_q >= trip_ms);
  wire rst_done  = (rst_cnt_q >= rst_ms);

  assign tk.run = run && !frz && (st_q != ST_IDLE);

  // state and counters
  always_comb begin
    st_d      = st_q;
    op_cnt_d  = op_cnt_q;
    rst_cnt_d = rst_cnt_q;
    if (!run) begin
      st_d      = ST_IDLE;
      op_cnt_d  = '0;
      rst_cnt_d = '0;
    end else if (!frz) begin
      case (st_q)
        ST_IDLE: begin
          if (detect_en) begin
            st_d     = ST_PICKUP;
            op_cnt_d = '0;
          end
        end
        ST_PICKUP: begin
          if (!detect_en) begin
            st_d      = ST_DROPOFF;
            rst_cnt_d = '0;
          end else if (op_done) begin
            st_d = ST_TRIPPED;
          end else if (tick) begin
            op_cnt_d = op_cnt_q + MS_W'(1);
          end
        end
        ST_DROPOFF: begin
          if (detect_en) begin
            st_d      = ST_PICKUP;
            rst_cnt_d = '0;
          end else if (rst_done) begin
            st_d      = ST_IDLE;
            op_cnt_d  = '0;
            rst_cnt_d = '0;
          end else if (tick) begin
            rst_cnt_d = rst_cnt_q + MS_W'(1);
          end
        end
        ST_TRIPPED: begin
          if (!detect_en) begin
            st_d     = ST_IDLE;
            op_cnt_d = '0;
          end
        end
        default: begin
          st_d      = ST_IDLE;
          op_cnt_d  = '0;
          rst_cnt_d = '0;
        end
      endcase
    end
  end

  // ratio of elapsed to trip delay, truncated, current on every cycle, clamped
  wire [31:0] pct_num = 32'(op_cnt_d) * 32'(PCT_FULL);
  wire [31:0] pct_quo = pct_num / 32'(trip_ms);

  always_comb begin
    pct_d = PCT_W'(pct_quo);
    if (pct_quo > 32'(PCT_FULL)) begin
      pct_d = PCT_FULL;
    end
    if (st_d == ST_TRIPPED) begin
      pct_d = PCT_FULL;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q      <= ST_IDLE;
      op_cnt_q  <= '0;
      rst_cnt_q <= '0;
      pct_q     <= '0;
    end else begin
      st_q      <= st_d;
      op_cnt_q  <= op_cnt_d;
      rst_cnt_q <= rst_cnt_d;
      pct_q     <= pct_d;
    end
  end

  // outputs follow the next state so pickup rises one edge after detection
  wire pickup_d = (st_d != ST_IDLE);
  wire trip_d   = (st_d == ST_TRIPPED) && !blk_trip;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pickup_q <= 1'b0;
      trip_q   <= 1'b0;
    end else begin
      pickup_q <= pickup_d;
      trip_q   <= trip_d;
    end
  end

  assign pickup = pickup_q;
  assign trip   = trip_q;

  // register access
  wire wr_ctrl  = reg_wr && (reg_addr == OFF_CTRL);
  wire wr_trip  = reg_wr && (reg_addr == OFF_TRIP_DLY);
  wire wr_rst   = reg_wr && (reg_addr == OFF_RST_DLY);
  wire wr_mask  = reg_wr && (reg_addr == OFF_IRQ_MASK);
  wire rd_irq   = reg_rd && (reg_addr == OFF_IRQ_STAT);

  wire [TRIP_STEP_W-1:0] trip_wr = reg_wdata[TRIP_STEP_W-1:0];
  wire [RST_STEP_W-1:0]  rst_wr  = reg_wdata[RST_STEP_W-1:0];
  wire [TRIP_STEP_W-1:0] trip_clamp =
    (trip_wr < TRIP_STEPS_MIN) ? TRIP_STEPS_MIN :
    (trip_wr > TRIP_STEPS_MAX) ? TRIP_STEPS_MAX : trip_wr;
  wire [RST_STEP_W-1:0] rst_clamp =
    (rst_wr > RST_STEPS_MAX) ? RST_STEPS_MAX : rst_wr;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_q         <= OP_ENABLE;
      blk_mode_q   <= BLK_FREEZE;
      trip_steps_q <= TRIP_STEPS_RST;
      rst_steps_q  <= RST_STEPS_RST;
      irq_mask_q   <= IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        op_q       <= reg_wdata[CTRL_OP_MSB:CTRL_OP_LSB];
        blk_mode_q <= reg_wdata[CTRL_BLK_MSB:CTRL_BLK_LSB];
      end
      if (wr_trip) begin
        trip_steps_q <= trip_clamp;
      end
      if (wr_rst) begin
        rst_steps_q <= rst_clamp;
      end
      if (wr_mask) begin
        irq_mask_q <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // sticky events; a new event wins over the read that clears
  wire [IRQ_W-1:0] irq_evt;
  assign irq_evt[IRQ_PICKUP] = pickup_d && !pickup_q;
  assign irq_evt[IRQ_TRIP]   = trip_d && !trip_q;
  assign irq_evt[IRQ_DROP]   = (st_q == ST_DROPOFF) && (st_d == ST_IDLE);
  assign irq_stat_d = (rd_irq ? '0 : irq_stat_q) | irq_evt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      OFF_CTRL: begin
        rd_mux[CTRL_OP_MSB:CTRL_OP_LSB]   = op_q;
        rd_mux[CTRL_BLK_MSB:CTRL_BLK_LSB] = blk_mode_q;
      end
      OFF_TRIP_DLY: rd_mux[TRIP_STEP_W-1:0] = trip_steps_q;
      OFF_RST_DLY:  rd_mux[RST_STEP_W-1:0]  = rst_steps_q;
      OFF_STATUS:   rd_mux[4:0] = {inhibit, (st_q == ST_DROPOFF),
                                   enabled, trip_q, pickup_q};
      OFF_RATIO:    rd_mux[PCT_W-1:0] = pct_q;
      OFF_ELAPSED:  rd_mux[MS_W-1:0]  = op_cnt_q;
      OFF_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
      OFF_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      default:      rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata = rdata_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_start;
    run && !frz && (st_q == ST_IDLE) && detect_en;
  endsequence

  sequence s_drop;
    run && !frz && (st_q == ST_PICKUP) && !detect_en;
  endsequence

  a_pickup_at_once: assert property (s_start |=> pickup)
    else $error("pickup not raised after detection");

  a_trip_on_delay: assert property (
    run && !frz && !blk_trip && (st_q == ST_PICKUP) && detect_en &&
    op_done |=> trip && (op_cnt_q >= trip_ms))
    else $error("trip not raised at trip delay");

  a_no_early_trip: assert property (
    $rose(trip) |-> $past(op_cnt_q) >= trip_ms)
    else $error("trip raised before delay elapsed");

  a_reset_timer_start: assert property (
    s_drop |=> (st_q == ST_DROPOFF) && pickup && $stable(op_cnt_q) &&
    (rst_cnt_q == '0))
    else $error("reset timer not started on drop");

  a_reset_expiry: assert property (
    run && !frz && (st_q == ST_DROPOFF) && !detect_en && rst_done
    |=> !pickup && (op_cnt_q == '0))
    else $error("reset delay expiry did not clear");

  a_ratio_bound: assert property (
    (pct_q <= PCT_FULL) && ((st_q != ST_IDLE) || (pct_q == '0)))
    else $error("ratio out of range");

  a_freeze_hold: assert property (frz |=> $stable(op_cnt_q) &&
    $stable(rst_cnt_q))
    else $error("timers moved while frozen");

  a_block_all: assert property (blk_all |=> !pickup && !trip &&
    (op_cnt_q == '0) && (rst_cnt_q == '0))
    else $error("block all left function active");

  a_no_trip_blocked: assert property (blk_trip |=> !trip)
    else $error("trip raised while output blocked");

  a_disabled_quiet: assert property (!enabled |=> !pickup &&
    !trip && (op_cnt_q == '0))
    else $error("disabled function active");

  a_tick_gated: assert property (
    (st_q != ST_PICKUP) || frz |=> $stable(op_cnt_q) ||
    (op_cnt_q == '0))
    else $error("operate timer advanced outside pickup");

  a_ratio_full: assert property (
    (st_q == ST_TRIPPED) |-> (pct_q == PCT_FULL))
    else $error("ratio not full after trip");

  a_ratio_zero: assert property (
    (op_cnt_q == '0) |-> (pct_q == '0))
    else $error("ratio not zero with timer clear");

  a_trip_needs_pickup: assert property (trip |-> pickup)
    else $error("trip without pickup");

  a_op_cnt_step: assert property (
    !$stable(op_cnt_q) && (op_cnt_q != '0) |->
    $past(tick) && (op_cnt_q == $past(op_cnt_q) + MS_W'(1)))
    else $error("operate timer moved without tick");

  a_rst_cnt_step: assert property (
    !$stable(rst_cnt_q) && (rst_cnt_q != '0) |-> $past(tick))
    else $error("reset timer moved without tick");
endmodule
